// >>> include/fimp_defines.svh
/*
 * Constants of the frame-indexed move and push-literal executor.
 * Assumes a 12-bit data space and a core that issues one command per idle.
 */
// Contract
// - Frame-indexed move copies the byte read at source to destination.
// - Source and destination are frame pointer plus separate 7-bit offsets.
// - Both computed addresses may lie anywhere in 000h to FFFh, unbanked.
// - A source address on an indirect register yields the byte 00h.
// - A destination address on an indirect register suppresses the write.
`ifndef FIMP_DEFINES_SVH
`define FIMP_DEFINES_SVH

`define FIMP_ADDR_W      12
`define FIMP_OFS_W       7
`define FIMP_DATA_W      8
`define FIMP_FP_RST      12'h000
`define FIMP_IND_LO      12'hFD9
`define FIMP_IND_HI      12'hFEF
`define FIMP_IND_BYTE    8'h00
`define FIMP_MOVE_CLKS   8
`define FIMP_PUSH_CLKS   4

`endif

// >>> include/fimp_pkg.sv
/*
 * Types shared by the executor, its memory model, checker and bench.
 * Assumes fimp_defines.svh is on the include path.
 */
`include "fimp_defines.svh"

package fimp_pkg;

   typedef enum logic [1:0] {
      FIMP_OP_NONE,
      FIMP_OP_MOVE,
      FIMP_OP_PUSH
   } fimp_op_t;

   typedef struct packed {
      fimp_op_t                     op;
      logic [`FIMP_OFS_W-1:0]       src_ofs;
      logic [`FIMP_OFS_W-1:0]       dst_ofs;
      logic [`FIMP_DATA_W-1:0]      literal;
   } fimp_cmd_t;

   typedef struct packed {
      logic                         rd;
      logic                         wr;
      logic [`FIMP_ADDR_W-1:0]      addr;
      logic [`FIMP_DATA_W-1:0]      wdata;
   } fimp_mem_req_t;

endpackage

// >>> hdl/fimp_addr_unit.sv
/*
 * Address unit: frame pointer plus an unsigned offset, and an indirect flag.
 * Assumes the indirect registers sit in one contiguous address window.
 */
`include "fimp_defines.svh"

module fimp_addr_unit #(
   parameter int AW = `FIMP_ADDR_W,
   parameter int OW = `FIMP_OFS_W
) (
   input  wire logic [AW-1:0] base_i,
   input  wire logic [OW-1:0] ofs_i,
   output logic      [AW-1:0] addr_o,
   output logic               indirect_o
);

   function automatic logic is_indirect(input logic [AW-1:0] a);
      is_indirect = (a >= AW'(`FIMP_IND_LO)) && (a <= AW'(`FIMP_IND_HI));
   endfunction

   // unsigned offset, wraps within the whole data space
   assign addr_o     = AW'(base_i + {{(AW-OW){1'b0}}, ofs_i});
   assign indirect_o = is_indirect(addr_o);

endmodule

// >>> hdl/fimp_exec.sv
/*
 * Executor for the frame-indexed move and the push-literal commands.
 * Assumes a decoder on clk_i presenting commands while ready_o is high,
 * and a data memory that returns read data one clock after mem rd.
 */
`include "fimp_defines.svh"

module fimp_exec #(
   parameter int AW = `FIMP_ADDR_W,
   parameter int OW = `FIMP_OFS_W,
   parameter int DW = `FIMP_DATA_W
) (
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              cmd_valid_i,
   input  wire fimp_pkg::fimp_cmd_t cmd_i,
   output logic                   ready_o,
   output logic                   done_o,
   input  wire logic              fp_load_i,
   input  wire logic [AW-1:0]     fp_load_data_i,
   output logic      [AW-1:0]     fp_o,
   output fimp_pkg::fimp_mem_req_t mem_req_o,
   input  wire logic [DW-1:0]     mem_rdata_i
);

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_MV_SRC,
      ST_MV_DST,
      ST_MV_RD,
      ST_MV_CAP,
      ST_MV_HOLD,
      ST_MV_PREP,
      ST_MV_WR,
      ST_PU_RD,
      ST_PU_PROC,
      ST_PU_WR
   } fimp_state_t;

   fimp_state_t             state_r;
   fimp_state_t             state_nxt;
   logic [AW-1:0]           fp_r;
   logic [OW-1:0]           src_ofs_r;
   logic [OW-1:0]           dst_ofs_r;
   logic [DW-1:0]           lit_r;
   logic [DW-1:0]           data_r;
   logic [AW-1:0]           src_addr_r;
   logic [AW-1:0]           dst_addr_r;
   logic                    src_ind_r;
   logic                    dst_ind_r;
   logic [AW-1:0]           src_addr;
   logic [AW-1:0]           dst_addr;
   logic                    src_ind;
   logic                    dst_ind;
   fimp_pkg::fimp_mem_req_t req_r;
   logic                    done_r;

   fimp_addr_unit #(
      .AW (AW),
      .OW (OW)
   ) u_src (
      .base_i     (fp_r),
      .ofs_i      (src_ofs_r),
      .addr_o     (src_addr),
      .indirect_o (src_ind)
   );

   fimp_addr_unit #(
      .AW (AW),
      .OW (OW)
   ) u_dst (
      .base_i     (fp_r),
      .ofs_i      (dst_ofs_r),
      .addr_o     (dst_addr),
      .indirect_o (dst_ind)
   );

   assign ready_o   = (state_r == ST_IDLE);
   assign done_o    = done_r;
   assign fp_o      = fp_r;
   assign mem_req_o = req_r;

   // sequencer: one state per clock phase of the instruction cycle
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (cmd_valid_i && cmd_i.op == fimp_pkg::FIMP_OP_MOVE)
            begin
               state_nxt = ST_MV_SRC;
            end
            else if (cmd_valid_i && cmd_i.op == fimp_pkg::FIMP_OP_PUSH)
            begin
               state_nxt = ST_PU_RD;
            end
         end
         ST_MV_SRC:  state_nxt = ST_MV_DST;
         ST_MV_DST:  state_nxt = ST_MV_RD;
         ST_MV_RD:   state_nxt = ST_MV_CAP;
         ST_MV_CAP:  state_nxt = ST_MV_HOLD;
         ST_MV_HOLD: state_nxt = ST_MV_PREP;
         ST_MV_PREP: state_nxt = ST_MV_WR;
         ST_MV_WR:   state_nxt = ST_IDLE;
         ST_PU_RD:   state_nxt = ST_PU_PROC;
         ST_PU_PROC: state_nxt = ST_PU_WR;
         ST_PU_WR:   state_nxt = ST_IDLE;
         default:    state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state_r <= ST_IDLE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // command operands captured on acceptance
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         src_ofs_r <= '0;
         dst_ofs_r <= '0;
         lit_r     <= '0;
      end
      else if (ready_o && cmd_valid_i)
      begin
         src_ofs_r <= cmd_i.src_ofs;
         dst_ofs_r <= cmd_i.dst_ofs;
         lit_r     <= cmd_i.literal;
      end
   end

   // frame pointer: decrement after push write, core load only when idle
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         fp_r <= AW'(`FIMP_FP_RST);
      end
      else if (state_r == ST_PU_WR)
      begin
         fp_r <= AW'(fp_r - AW'(1));
      end
      else if (fp_load_i && ready_o)
      begin
         fp_r <= fp_load_data_i;
      end
   end

   // computed addresses latched in their own phases
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         src_addr_r <= '0;
         src_ind_r  <= 1'b0;
         dst_addr_r <= '0;
         dst_ind_r  <= 1'b0;
      end
      else if (state_r == ST_MV_SRC)
      begin
         src_addr_r <= src_addr;
         src_ind_r  <= src_ind;
      end
      else if (state_r == ST_MV_DST)
      begin
         dst_addr_r <= dst_addr;
         dst_ind_r  <= dst_ind;
      end
   end

   // moved byte: memory data, or zero for an indirect source
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         data_r <= '0;
      end
      else if (state_r == ST_MV_CAP)
      begin
         if (src_ind_r)
         begin
            data_r <= DW'(`FIMP_IND_BYTE);
         end
         else
         begin
            data_r <= mem_rdata_i;
         end
      end
   end

   // registered memory request, decoded from the next state so it is issued in the same clock as its state
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         req_r <= '0;
      end
      else
      begin
         req_r <= '0;
         case (state_nxt)
            ST_MV_RD:
            begin
               // indirect source is never read, avoiding side effects
               req_r.rd   <= ~src_ind_r;
               req_r.addr <= src_addr_r;
            end
            ST_MV_WR:
            begin
               req_r.wr    <= ~dst_ind_r;
               req_r.addr  <= dst_addr_r;
               req_r.wdata <= data_r;
            end
            ST_PU_WR:
            begin
               req_r.wr    <= 1'b1;
               req_r.addr  <= fp_r;
               req_r.wdata <= lit_r;
            end
            default:
            begin
               req_r <= '0;
            end
         endcase
      end
   end

   // completion pulse with the final phase
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= (state_nxt == ST_MV_WR) || (state_nxt == ST_PU_WR);
      end
   end

endmodule

// >>> sim/fimp_mem_model.sv
/* data memory partner of the executor.
   assumes requests are one-cycle pulses on the executor's clock. */
module fimp_mem_model (
   input  wire logic                    clk_i,
   input  wire fimp_pkg::fimp_mem_req_t req_i,
   output logic [7:0]                   rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [4096];
   initial rdata_o = 8'h00;
   always @(posedge clk_i)
   begin
      if (req_i.wr)
         mem[req_i.addr] <= req_i.wdata;
      // data valid one cycle only, then scrambled
      rdata_o <= req_i.rd ? mem[req_i.addr] : ~rdata_o;
   end
endmodule

// >>> sim/fimp_exec_asserts.sv
/* port checker for fimp_exec, bound below.
   assumes fimp_pkg and fimp_defines.svh are compiled first. */
`include "fimp_defines.svh"
module fimp_exec_asserts #(
   parameter int AW = `FIMP_ADDR_W,
   parameter int OW = `FIMP_OFS_W,
   parameter int DW = `FIMP_DATA_W
) (
   input wire logic                    clk_i,
   input wire logic                    sys_rst_i,
   input wire logic                    cmd_valid_i,
   input wire fimp_pkg::fimp_cmd_t     cmd_i,
   input wire logic                    ready_o,
   input wire logic                    done_o,
   input wire logic                    fp_load_i,
   input wire logic [AW-1:0]           fp_load_data_i,
   input wire logic [AW-1:0]           fp_o,
   input wire fimp_pkg::fimp_mem_req_t mem_req_o,
   input wire logic [DW-1:0]           mem_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [AW-1:0] sa, da;
   logic          mv, ps, si, di;
   assign sa = fp_o + AW'(cmd_i.src_ofs);
   assign da = fp_o + AW'(cmd_i.dst_ofs);
   assign si = sa inside {[`FIMP_IND_LO:`FIMP_IND_HI]};
   assign di = da inside {[`FIMP_IND_LO:`FIMP_IND_HI]};
   assign mv = cmd_valid_i && ready_o && cmd_i.op == fimp_pkg::FIMP_OP_MOVE;
   assign ps = cmd_valid_i && ready_o && cmd_i.op == fimp_pkg::FIMP_OP_PUSH;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_mv_rd;
      mv && !si |-> ##3 mem_req_o.rd && mem_req_o.addr == $past(sa, 3);
   endproperty
   a_mv_rd: assert property (p_mv_rd) else $error("bad read");
   property p_mv_wr;
      mv && !di |-> ##7 done_o && mem_req_o.wr && mem_req_o.addr == $past(da, 7);
   endproperty
   a_mv_wr: assert property (p_mv_wr) else $error("bad write");
   property p_mv_dat;
      mem_req_o.rd |-> ##4
         (!mem_req_o.wr || mem_req_o.wdata == $past(mem_rdata_i, 3));
   endproperty
   a_mv_dat: assert property (p_mv_dat) else $error("bad data");
   property p_src_ind;
      mv && si |-> ##3 !mem_req_o.rd ##4
         (!mem_req_o.wr || mem_req_o.wdata == `FIMP_IND_BYTE);
   endproperty
   a_src_ind: assert property (p_src_ind) else $error("bad src");
   property p_dst_ind;
      mv && di |-> ##7 done_o && !mem_req_o.wr;
   endproperty
   a_dst_ind: assert property (p_dst_ind) else $error("bad nop");
   property p_ps_wr;
      ps |-> ##3 done_o && mem_req_o.wr && mem_req_o.addr == $past(fp_o, 3)
         && mem_req_o.wdata == $past(cmd_i.literal, 3);
   endproperty
   a_ps_wr: assert property (p_ps_wr) else $error("bad push");
   property p_ps_fp;
      ps |-> ##4 ready_o && fp_o == $past(fp_o, 4) - 1'b1;
   endproperty
   a_ps_fp: assert property (p_ps_fp) else $error("bad fp");
   c_move: cover property (mv && !si && !di);
   c_ind: cover property (mv && (si || di));
   c_push: cover property (ps);
endmodule

bind fimp_exec fimp_exec_asserts #(.AW(AW), .OW(OW), .DW(DW)) chk_u (
   .clk_i, .sys_rst_i, .cmd_valid_i, .cmd_i, .ready_o, .done_o, .fp_load_i,
   .fp_load_data_i, .fp_o, .mem_req_o, .mem_rdata_i
);

// >>> sim/fimp_exec_tb_top.sv
/* self-checking bench for fimp_exec with a data memory model.
   assumes the package, design and checker are compiled first. */
`include "fimp_defines.svh"
module fimp_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    clk_i, sys_rst_i, cv, fl, rdy, dn;
   logic [11:0]             fd, fp;
   logic [7:0]              rd;
   fimp_pkg::fimp_cmd_t     cmd;
   fimp_pkg::fimp_mem_req_t req;
   int                      bad_count = 0;
   int                      num_checks = 0;
   fimp_exec dut_u (.clk_i, .sys_rst_i, .cmd_valid_i(cv), .cmd_i(cmd),
      .ready_o(rdy), .done_o(dn), .fp_load_i(fl), .fp_load_data_i(fd),
      .fp_o(fp), .mem_req_o(req), .mem_rdata_i(rd));
   fimp_mem_model mem_u (.clk_i, .req_i(req), .rdata_o(rd));
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input string n, input logic [11:0] s, e);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   task test_done;
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic run(input fimp_pkg::fimp_op_t o, input logic [6:0] s, d,
                      input logic [7:0] k, input int lat);
      int n;
      n = 0;
      @(posedge clk_i);
      cv <= 1'b1;
      cmd <= '{o, s, d, k};
      @(posedge clk_i);
      cv <= 1'b0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (dn !== 1'b1 && n < 20);
      chk("latency", 12'(n), 12'(lat));
      chk("busy", 12'(rdy), 12'h000);
      // final write lands at the next edge
      @(negedge clk_i);
      chk("ready", 12'(rdy), 12'h001);
   endtask
   // load frame pointer, preload source byte, run one move
   task automatic mv(input logic [11:0] f, input logic [6:0] s, d,
                     input logic [7:0] v);
      @(posedge clk_i);
      fl <= 1'b1;
      fd <= f;
      @(posedge clk_i);
      fl <= 1'b0;
      mem_u.mem[f + 12'(s)] = v;
      run(fimp_pkg::FIMP_OP_MOVE, s, d, 8'h00, `FIMP_MOVE_CLKS - 1);
   endtask
   task t_move_basic;
      mv(12'h080, 7'h05, 7'h06, 8'h33);
      chk("dst", 12'(mem_u.mem[12'h086]), 12'h033);
   endtask
   task t_move_top;
      mv(12'hF50, 7'h00, 7'h7F, 8'hC3);
      chk("top", 12'(mem_u.mem[12'hFCF]), 12'h0C3);
   endtask
   task t_src_ind;
      mem_u.mem[12'hF60] = 8'h77;
      mv(12'hF60, 7'h7F, 7'h00, 8'h55);
      chk("zero", 12'(mem_u.mem[12'hF60]), 12'h000);
   endtask
   task t_dst_ind;
      mem_u.mem[12'hFDA] = 8'hA5;
      mv(12'hFD0, 7'h00, 7'h0A, 8'h5A);
      chk("nop", 12'(mem_u.mem[12'hFDA]), 12'h0A5);
   endtask
   task t_push;
      mv(12'h1EC, 7'h00, 7'h00, 8'h11);
      run(fimp_pkg::FIMP_OP_PUSH, 7'h00, 7'h00, 8'h08, `FIMP_PUSH_CLKS - 1);
      run(fimp_pkg::FIMP_OP_PUSH, 7'h00, 7'h00, 8'h5A, `FIMP_PUSH_CLKS - 1);
      @(negedge clk_i);
      chk("p0", 12'(mem_u.mem[12'h1EC]), 12'h008);
      chk("p1", 12'(mem_u.mem[12'h1EB]), 12'h05A);
      chk("fp", fp, 12'h1EA);
   endtask
   initial
   begin
      repeat (2000) @(posedge clk_i);
      bad_count++;
      test_done;
   end
   initial
   begin
      sys_rst_i = 1'b1;
      cv = 1'b0;
      fl = 1'b0;
      fd = 12'h000;
      cmd = '0;
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_move_basic;
      t_move_top;
      t_src_ind;
      t_dst_ind;
      t_push;
      test_done;
   end
endmodule
